// [hdl/host_pio_bus_port.sv]
// programmed-I/O host bus port: two bus styles, 15-bit address, 8-bit data
// assumes all host pins are asynchronous to clk_sys; data pin is three signals
`include "host_port_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module host_pio_bus_port
	import host_port_pkg::*;
#(
	parameter int MEM_DEPTH    = `MEM_DEPTH,
	parameter int SETTLE_CYC   = `READ_SETTLE_CYC,
	parameter int SETUP_CYC    = `WRITE_SETUP_CYC
)
(
	// clock and reset
	input  wire logic               clk_sys,
	input  wire logic               rst_b,
	// host control pins
	input  wire logic               bus_style_select,
	input  wire logic               chip_sel_b,
	input  wire logic               addr_latch_strobe,
	input  wire logic               read_or_data_strobe,
	input  wire logic               write_strobe_or_dir_select,
	input  wire logic [`ADDR_W-1:0] addr_in,
	// data pins
	input  wire logic [`DATA_W-1:0] data_in,
	output logic [`DATA_W-1:0]      data_out,
	output logic                    data_oe_b,
	// handshake back to host
	output logic                    transfer_acknowledge
);

	// wait counter is eight bits wide
	if (SETTLE_CYC < 1 || SETTLE_CYC > 255 || SETUP_CYC < 1 || SETUP_CYC > 255)
	begin : g_bad_wait
		$error("host_pio_bus_port: wait counts must be 1..255");
	end

	// two-stage sync of every asynchronous pin
	localparam int NS = 5;
	logic [NS-1:0] pin_raw;
	logic [NS-1:0] sync1_q;
	logic [NS-1:0] sync2_q;
	logic [NS-1:0] sync3_q;
	logic [`ADDR_W-1:0] addr_s1_q;
	logic [`ADDR_W-1:0] addr_s2_q;
	logic [`DATA_W-1:0] data_s1_q;
	logic [`DATA_W-1:0] data_s2_q;

	assign pin_raw = {bus_style_select, chip_sel_b, addr_latch_strobe,
		read_or_data_strobe, write_strobe_or_dir_select};

	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
		begin
			sync1_q <= 5'b0_1011;
			sync2_q <= 5'b0_1011;
			sync3_q <= 5'b0_1011;
		end
		else
		begin
			sync1_q <= pin_raw; // RL20
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	// address and data words pass the same two stages
	always_ff @(posedge clk_sys)
	begin
		addr_s1_q <= addr_in;
		addr_s2_q <= addr_s1_q;
		data_s1_q <= data_in;
		data_s2_q <= data_s1_q;
	end

	logic style_hi;
	logic cs_b;
	logic als;
	logic rds;
	logic wrs;
	logic als_fall;
	logic als_rise;
	logic rds_fall;
	logic rds_rise;
	logic wrs_fall;
	logic wrs_rise;

	assign style_hi = sync2_q[4];
	assign cs_b     = sync2_q[3];
	assign als      = sync2_q[2];
	assign rds      = sync2_q[1];
	assign wrs      = sync2_q[0];
	assign als_fall = sync3_q[2] & ~als; // RL20
	assign als_rise = ~sync3_q[2] & als;
	assign rds_fall = sync3_q[1] & ~rds;
	assign rds_rise = ~sync3_q[1] & rds;
	assign wrs_fall = sync3_q[0] & ~wrs;
	assign wrs_rise = ~sync3_q[0] & wrs;

	// address latch
	logic [`ADDR_W-1:0] addr_q;
	logic               addr_cap;

	// RL11: style pin low selects separate read/write strobes
	assign addr_cap = ~cs_b & (style_hi ? als_rise : als_fall); // RL2 RL3 RL12

	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
			addr_q <= 15'h0000;
		else if (addr_cap)
			addr_q <= addr_s2_q;
	end

	// cycle start and end decode per style
	logic rd_start;
	logic wr_start;
	logic rd_end;
	logic wr_end;

	always_comb
	begin
		if (style_hi)
		begin
			rd_start = ~cs_b & rds_fall & wrs; // RL13 RL14
			wr_start = ~cs_b & rds_fall & ~wrs; // RL13 RL17
			rd_end   = rds_rise;
			wr_end   = rds_rise; // RL19
		end
		else
		begin
			rd_start = ~cs_b & rds_fall; // RL4
			wr_start = ~cs_b & wrs_fall; // RL9
			rd_end   = rds_rise; // RL8
			wr_end   = wrs_rise; // RL10
		end
	end

	// cycle state
	port_state_t state_q;
	logic [7:0]  wait_q;
	logic        ack_q;

	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
			state_q <= ST_IDLE;
		else
		begin
			case (state_q)
				ST_IDLE:
				begin
					if (rd_start)
						state_q <= ST_READ;
					else if (wr_start)
						state_q <= ST_WRITE;
				end
				ST_READ:
				begin
					if (rd_end)
						state_q <= ST_IDLE; // RL8
				end
				ST_WRITE:
				begin
					if (wr_end)
						state_q <= ST_DONE; // RL10 RL19
				end
				ST_DONE:
					state_q <= ST_IDLE;
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// settle / setup counter before the acknowledge
	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
		begin
			wait_q <= 8'h00;
			ack_q  <= 1'b0;
		end
		// a start inside an open cycle is ignored, as in the state machine
		else if (rd_start && state_q == ST_IDLE)
		begin
			wait_q <= 8'(SETTLE_CYC);
			ack_q  <= 1'b0; // RL5
		end
		else if (wr_start && state_q == ST_IDLE)
		begin
			wait_q <= 8'(SETUP_CYC);
			ack_q  <= 1'b0;
		end
		else if (state_q == ST_READ || state_q == ST_WRITE)
		begin
			if (wait_q != 8'h00)
				wait_q <= wait_q - 8'h01;
			else
				ack_q <= 1'b1; // RL6 RL15 RL18
		end
		else
			ack_q <= 1'b0;
	end

	// separate-strobe style: ready low while a read settles, else high.
	// strobe-and-direction style: acknowledge high when the cycle may finish.
	// the pin polarity is the one mux below; host logic must know the style.
	always_comb
	begin
		if (style_hi)
			transfer_acknowledge = ack_q; // RL15 RL18
		else
			transfer_acknowledge = ~(state_q == ST_READ) | ack_q; // RL5 RL6
	end

	// store access: write uses the data seen just before the rising strobe
	loc_req_t req;
	logic [`DATA_W-1:0] rdata;
	logic [`DATA_W-1:0] wdata_q;

	// data held in the strobe-low window; the rising edge is seen two clocks late
	always_ff @(posedge clk_sys)
	begin
		if (state_q == ST_WRITE && !wr_end)
			wdata_q <= data_s2_q;
	end

	always_comb
	begin
		req.wr    = (state_q == ST_DONE); // RL10 RL19
		req.addr  = addr_q;
		req.wdata = wdata_q;
	end

	loc_store #(
		.DEPTH (MEM_DEPTH)
	) u_store (
		.clk_sys (clk_sys),
		.req     (req),
		.rdata   (rdata)
	);

	// data bus drivers, enable active low
	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
		begin
			data_out  <= 8'h00;
			data_oe_b <= 1'b1;
		end
		else
		begin
			data_out  <= rdata; // RL4 RL14
			data_oe_b <= ~(state_q == ST_READ) | rd_end; // RL8 RL9 RL17
		end
	end

endmodule

`default_nettype wire

// [hdl/host_port_cfg.svh]
// constants for the programmed-I/O host bus port
// assumes a 250 MHz internal clock sampling asynchronous host pins
//
// Overview of operation
// [RL1] host presents a 15-bit location address before latching it
// [RL2] bus cycles count only while active-low chip select is low
// [RL3] strobe-high style: address captured on falling edge of latch strobe
// [RL4] strobe-high style read: low read strobe enables drivers with addressed byte
// [RL5] ready goes low right after read strobe falls
// [RL6] ready returns high once read data is stable
// [RL7] host waits for ready, then raises read strobe
// [RL8] raised read strobe releases the data bus
// [RL9] write strobe low enables input path, drivers stay off
// [RL10] byte stored on rising write strobe, which ends the cycle
// [RL11] style select low picks separate-strobe style, high picks strobe-and-direction style
// [RL12] strobe-and-direction style: address captured on rising edge of active-low address strobe
// [RL13] direction select high means read, low means write
// [RL14] data strobe low in a read drives the addressed byte
// [RL15] acknowledge asserted once read data is stable
// [RL16] host waits for acknowledge, then raises data strobe
// [RL17] data strobe low in a write enables input path only
// [RL18] acknowledge asserted after write data setup time
// [RL19] byte stored on rising data strobe after acknowledge, ending the cycle
// [RL20] strobes synchronised and edge-detected internally; chip select is synchronised but only used as a level
`ifndef HOST_PORT_CFG_SVH
`define HOST_PORT_CFG_SVH

`define ADDR_W          15
`define DATA_W          8
`define CLK_PERIOD_PS   4000
// settling time before read data is called stable, and write data setup time
`define READ_SETTLE_NS  20
`define WRITE_SETUP_NS  20
`define READ_SETTLE_CYC ((`READ_SETTLE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define WRITE_SETUP_CYC ((`WRITE_SETUP_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define MEM_DEPTH       256

`endif

// [hdl/host_port_pkg.sv]
// types shared by the host bus port
// assumes host_port_cfg.svh for widths
`include "host_port_cfg.svh"

package host_port_pkg;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_READ  = 4'b0010,
		ST_WRITE = 4'b0100,
		ST_DONE  = 4'b1000
	} port_state_t;

	// one access toward the location store
	typedef struct packed {
		logic                 wr;
		logic [`ADDR_W-1:0]   addr;
		logic [`DATA_W-1:0]   wdata;
	} loc_req_t;

endpackage

// [hdl/loc_store.sv]
// small byte store standing in for the registers and buffers behind the port
// assumes one request a cycle; read data come out of a register
`include "host_port_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module loc_store
	import host_port_pkg::*;
#(
	parameter int DEPTH = `MEM_DEPTH
)
(
	// clock
	input  wire logic               clk_sys,
	// access
	input  wire loc_req_t           req,
	output logic [`DATA_W-1:0]      rdata
);

	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || DEPTH > (1 << `ADDR_W))
	begin : g_bad_depth
		$error("loc_store: DEPTH out of range");
	end

	logic [`DATA_W-1:0] mem [DEPTH];

	always_ff @(posedge clk_sys)
	begin
		if (req.wr)
			mem[req.addr[AW-1:0]] <= req.wdata;
	end

	always_ff @(posedge clk_sys)
	begin
		rdata <= mem[req.addr[AW-1:0]];
	end

endmodule

`default_nettype wire

// [bench/host_port_checker.sv]
// pin-level assertions for the host bus port
// assumes bus_style_select only changes while chip_sel_b is high
`include "host_port_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module host_port_checker
(
	// clock and reset
	input wire logic               clk_sys,
	input wire logic               rst_b,
	// host pins
	input wire logic               bus_style_select,
	input wire logic               chip_sel_b,
	input wire logic               read_or_data_strobe,
	input wire logic               write_strobe_or_dir_select,
	// device pins
	input wire logic [`DATA_W-1:0] data_out,
	input wire logic               data_oe_b,
	input wire logic               transfer_acknowledge
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	sequence rd_go;
		$fell(read_or_data_strobe) && !chip_sel_b && !bus_style_select
			&& write_strobe_or_dir_select;
	endsequence
	sequence ds_go;
		$fell(read_or_data_strobe) && !chip_sel_b && bus_style_select;
	endsequence
	read_drive_a: assert property (rd_go |-> ##[2:5] !data_oe_b) else $error("oe late");
	ready_low_a: assert property (rd_go |-> ##[1:4] !transfer_acknowledge)
		else $error("ready stayed high");
	ready_high_a: assert property (rd_go |-> ##[5:10] transfer_acknowledge)
		else $error("ready never rose");
	bus_release_a: assert property ($rose(read_or_data_strobe) |-> ##[1:5] data_oe_b)
		else $error("bus held");
	write_quiet_a: assert property (!bus_style_select && !write_strobe_or_dir_select
		|-> data_oe_b) else $error("drove in write");
	dir_write_quiet_a: assert property (bus_style_select && !write_strobe_or_dir_select
		&& !read_or_data_strobe |-> data_oe_b) else $error("drove in write");
	ack_timing_a: assert property (ds_go |-> !transfer_acknowledge[*3]
		##[1:8] transfer_acknowledge) else $error("ack timing");
	deselect_idle_a: assert property ((chip_sel_b && $stable(bus_style_select))[*8]
		|-> data_oe_b && transfer_acknowledge != bus_style_select) else $error("not idle");
	read_hold_a: assert property (!data_oe_b && !$past(data_oe_b) |-> $stable(data_out))
		else $error("read data moved");
endmodule

bind host_pio_bus_port host_port_checker chk_i (
	.clk_sys                    (clk_sys),
	.rst_b                      (rst_b),
	.bus_style_select           (bus_style_select),
	.chip_sel_b                 (chip_sel_b),
	.read_or_data_strobe        (read_or_data_strobe),
	.write_strobe_or_dir_select (write_strobe_or_dir_select),
	.data_out                   (data_out),
	.data_oe_b                  (data_oe_b),
	.transfer_acknowledge       (transfer_acknowledge)
);

`default_nettype wire

// [bench/host_cpu_model.sv]
// host processor model that runs single-byte cycles on the port pins
// assumes the bench calls cyc; pins change 1 ns after a clk_sys edge
`include "host_port_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module host_cpu_model
(
	// clock
	input wire logic                clk_sys,
	// host pins
	output var logic                bus_style_select,
	output var logic                chip_sel_b,
	output var logic                addr_latch_strobe,
	output var logic                read_or_data_strobe,
	output var logic                write_strobe_or_dir_select,
	output var logic [`ADDR_W-1:0]  addr_in,
	output wire logic [`DATA_W-1:0] data_in,
	// device pins
	input wire logic [`DATA_W-1:0]  data_out,
	input wire logic                data_oe_b,
	input wire logic                transfer_acknowledge
);
	logic               hd;
	logic [`DATA_W-1:0] hv;
	// a released bus shows the inverse, so stale data cannot pass
	assign data_in = !data_oe_b ? data_out : hd ? hv : ~hv;
	initial
	begin
		{bus_style_select, addr_latch_strobe, chip_sel_b} = 3'h1;
		{read_or_data_strobe, write_strobe_or_dir_select, hd} = 3'h6;
		addr_in = 15'h0000;
		hv = 8'h00;
	end
	task automatic step(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask
	task automatic cyc(input logic st, wr, cs_n, input logic [`ADDR_W-1:0] a,
		input logic [`DATA_W-1:0] d, output logic [`DATA_W-1:0] q);
		int n;
		bus_style_select = st;
		addr_latch_strobe = st;
		write_strobe_or_dir_select = st ? !wr : 1'b1;
		step(4);
		chip_sel_b = cs_n;
		addr_in = a;
		addr_latch_strobe = !st;
		step(4);
		addr_latch_strobe = st;
		step(4);
		hv = d;
		hd = wr;
		if (wr && !st)
			write_strobe_or_dir_select = 1'b0;
		else
			read_or_data_strobe = 1'b0;
		// look one step after each edge, where the answer has settled
		step(8);
		n = 0;
		while (transfer_acknowledge !== 1'b1 && n < 40)
		begin
			step(1);
			n++;
		end
		q = (n < 40) ? data_in : 'x;
		// ack is sampled high at the next edge; release just after it
		step(1);
		read_or_data_strobe = 1'b1;
		write_strobe_or_dir_select = st ? !wr : 1'b1;
		// data held past the rise, the port samples it late
		step(4);
		hd = 1'b0;
		chip_sel_b = 1'b1;
		step(4);
	endtask
endmodule

`default_nettype wire

// [bench/test_host_pio_bus_port.sv]
// self-checking bench for the host bus port
// assumes host_cpu_model plays the host and the checker is bound in
`include "host_port_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(w, e, a) begin checks_done++; if ((a) !== (e)) begin failures++; \
	$display("wrong value %s expected %h seen %h", w, e, a); end end

module test_host_pio_bus_port
	import host_port_pkg::*;
;
	logic                bus_style_select, chip_sel_b, addr_latch_strobe;
	logic                read_or_data_strobe, write_strobe_or_dir_select;
	logic [`ADDR_W-1:0]  addr_in, a;
	wire [`DATA_W-1:0]   data_in;
	logic [`DATA_W-1:0]  data_out, q, d;
	logic [`DATA_W-1:0]  mem [256];
	logic                data_oe_b, transfer_acknowledge;
	logic                clk_sys = 1'b0;
	logic                rst_b = 1'b0;
	int                  failures = 0;
	int                  checks_done = 0;
	int                  seed;
	host_pio_bus_port host_pio_bus_port_i (.*);
	host_cpu_model host_cpu_model_i (.*);
	initial
	begin
		forever #2 clk_sys = ~clk_sys;
	end
	function automatic logic [`DATA_W-1:0] exp_of(input logic [`ADDR_W-1:0] ad);
		return mem[ad[7:0]];
	endfunction
	task automatic final_report();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		#100000;
		failures++;
		final_report();
	end
	initial
	begin
		seed = 32'h0000_eb4b;
		repeat (2) @(posedge clk_sys);
		#1 rst_b = 1'b1;
		`CHK("oe after reset", 1'b1, data_oe_b)
		for (int i = 0; i < 24; i++)
		begin
			// first rounds hit the lowest and highest address
			a = (i < 4) ? {`ADDR_W{i[1]}} : `ADDR_W'($random(seed));
			d = `DATA_W'($random(seed));
			host_cpu_model_i.cyc(i[0], 1'b1, 1'b0, a, d, q);
			mem[a[7:0]] = d;
			host_cpu_model_i.cyc(!i[0], 1'b1, 1'b1, a, ~d, q);
			host_cpu_model_i.cyc(i[1], 1'b0, 1'b0, a, 8'h00, q);
			`CHK("read byte", exp_of(a), q)
		end
		rst_b = 1'b0;
		repeat (2) @(posedge clk_sys);
		#1 rst_b = 1'b1;
		`CHK("oe after second reset", 1'b1, data_oe_b)
		host_cpu_model_i.cyc(1'b0, 1'b0, 1'b0, a, 8'h00, q);
		`CHK("read after reset", exp_of(a), q)
		final_report();
	end
endmodule

`default_nettype wire
